// [shared/psc_link_if.sv]
`timescale 1ns/10ps
interface psc_link_if;
    import psc_pkg::*;
    logic [WORD_W-1:0] word;
    logic chain_bit;
    modport shifter (output word, output chain_bit);
    modport core (input word, input chain_bit);
endinterface

// [shared/psc_pkg.sv]
package psc_pkg;
    // Widths.
    localparam int WORD_W = 6;
    localparam int ANGLE_W = 19;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_W = 7;
    localparam int CNT_W = 16;
    localparam int GAP_W = 8;
    // Positions in the synchronised pin vector; bits 5..0 are the phase bits.
    localparam int PIN_MODE = 6;
    localparam int PIN_LE = 2;
    // One phase step in millidegrees (5.625 degrees).
    localparam logic [ANGLE_W-1:0] STEP_MDEG = 19'h015F9;
    // Timing.
    localparam int MCLK_PERIOD_NS = 5;
    localparam int SCLK_MIN_PERIOD_NS = 100;
    localparam int LE_SPACING_NS = 630;
    localparam int LE_GAP_CYC_I = (LE_SPACING_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [GAP_W-1:0] LE_GAP_CYC = GAP_W'(LE_GAP_CYC_I);
    // Register map.
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ANGLE = 8'h0C;
    localparam int CTRL_CNT_EN = 0;
    localparam int CTRL_CNT_CLR = 1;
    localparam int CTRL_ERR_CLR = 2;
    localparam int STAT_MODE = 6;
    localparam int STAT_ERR = 7;
    // Reset values.
    localparam logic CTRL_CNT_EN_RESET = 1'h1;
    localparam logic [WORD_W-1:0] PHASE_RESET = 6'h00;
endpackage

// [tb/psc_ctrl_tb.sv]
`timescale 1ns/10ps
module psc_ctrl_tb;
    import psc_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic mode, le4, clk2, sin1, sout;
    logic [2:0] hi;
    logic [WORD_W-1:0] phase;
    logic [ANGLE_W-1:0] angle;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    int hist[$] = '{0, 0, 0, 0, 0, 0};
    int strobes = 0;
    logic [31:0] lfsr_q = 32'h6C65;
    logic [5:0] exp_ph = 6'h00;

    always #2.5 mclk_in = ~mclk_in;

    psc_ctrl psc_ctrl_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .mode_select_in(mode), .phase_bit_step32_in(hi[2]),
        .phase_bit_step16_in(hi[1]), .phase_bit_step8_in(hi[0]),
        .latch_strobe_or_step4_in(le4), .serial_clk_or_step2_in(clk2),
        .serial_in_or_step1_in(sin1), .serial_out_out(sout),
        .phase_state_out(phase), .phase_angle_out(angle), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));

    psc_host psc_host_inst (.mode_out(mode), .hi_bits_out(hi), .le_or4_out(le4),
        .clk_or2_out(clk2), .sin_or1_out(sin1));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask

    task automatic ph_chk();
        repeat (8) @(posedge mclk_in);
        #1;
        check(32'(phase), 32'(exp_ph));
        check(32'(angle), 32'(exp_ph) * 32'h15F9);
    endtask

    task automatic shift(input logic b);
        psc_host_inst.send_bit(b);
        hist.push_back(int'(b));
        check(32'(sout), 32'(hist[hist.size() - 6]));
        check(32'(phase), 32'(exp_ph));
    endtask

    task automatic load(input int nbits, input logic [7:0] w, input logic clk_b);
        for (int i = nbits - 1; i >= 0; i--) shift(w[i]);
        // A clock pulse inside the strobe must not move the chain.
        psc_host_inst.strobe(clk_b, 22);
        for (int i = 0; i < 6; i++) exp_ph[i] = hist[hist.size() - 1 - i][0];
        strobes++;
        ph_chk();
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        reg_chk(REG_CTRL, 32'h1);
        reg_chk(8'h10, 32'h0);
        ph_chk();
        // Walking ones, all ones, then random words on the parallel pins.
        for (int i = 0; i < 14; i++) begin
            exp_ph = (i < 6) ? 6'h01 << i : (i == 6) ? 6'h3F : lfsr_q[5:0];
            lfsr_q = lfsr_next(lfsr_q);
            psc_host_inst.set_par(exp_ph);
            ph_chk();
            reg_chk(REG_STATUS, {24'h0, 2'h0, exp_ph});
            reg_chk(REG_ANGLE, 32'(exp_ph) * 32'h15F9);
        end
        psc_host_inst.go_serial();
        ph_chk();
        // Two zero clocks let the mode reach the link side; zeros leave the chain unchanged.
        psc_host_inst.send_bit(1'b0);
        psc_host_inst.send_bit(1'b0);
        for (int k = 0; k < 6; k++) begin
            load((k == 5) ? 8 : 6, lfsr_q[7:0], k[0]);
            lfsr_q = lfsr_next(lfsr_q);
        end
        reg_chk(REG_COUNT, 32'(strobes));
        reg_chk(REG_STATUS, {24'h0, 2'h1, exp_ph});
        // Two strobes about 180 ns apart still load the frozen word but raise the flag.
        psc_host_inst.strobe(1'b1, 2);
        psc_host_inst.strobe(1'b0, 2);
        strobes += 2;
        ph_chk();
        reg_chk(REG_STATUS, {24'h0, 2'h3, exp_ph});
        reg_chk(REG_COUNT, 32'(strobes));
        reg_wr(REG_CTRL, 32'h7);
        reg_chk(REG_COUNT, 32'h0);
        reg_chk(REG_STATUS, {24'h0, 2'h1, exp_ph});
        exp_ph = lfsr_q[5:0];
        psc_host_inst.set_par(exp_ph);
        ph_chk();
        conclude();
    end
endmodule

// [tb/psc_host.sv]
`timescale 1ns/10ps
module psc_host (
    // Pins towards the device.
    output logic mode_out,
    output logic [2:0] hi_bits_out,
    output logic le_or4_out,
    output logic clk_or2_out,
    output logic sin_or1_out
);
    logic tick = 1'b0;

    // Base tick of 30 ns, unrelated in phase; the serial clock pin moves only in frames.
    initial begin
        #7;
        forever #15 tick = ~tick;
    end

    initial begin
        mode_out = 1'b0;
        hi_bits_out = 3'h0;
        {le_or4_out, clk_or2_out, sin_or1_out} = 3'h0;
    end

    task automatic set_par(input logic [5:0] w);
        @(posedge tick);
        mode_out = 1'b0;
        {hi_bits_out, le_or4_out, clk_or2_out, sin_or1_out} = w;
    endtask

    // Mode goes first so the shared pins never act as phase bits on the way.
    task automatic go_serial();
        @(posedge tick);
        mode_out = 1'b1;
        @(posedge tick);
        {le_or4_out, clk_or2_out} = 2'h0;
    endtask

    task automatic send_bit(input logic b);
        @(posedge tick);
        sin_or1_out = b;
        @(posedge tick);
        clk_or2_out = 1'b1;
        repeat (2) @(posedge tick);
        clk_or2_out = 1'b0;
        // Hold time is over, so the line no longer shows the bit.
        sin_or1_out = ~b;
    endtask

    // Quiet gap after the strobe, in ticks; short gaps provoke the spacing flag.
    task automatic strobe(input logic clk_b, input int quiet);
        @(posedge tick);
        le_or4_out = 1'b1;
        @(posedge tick);
        sin_or1_out = clk_b;
        clk_or2_out = 1'b1;
        @(posedge tick);
        clk_or2_out = 1'b0;
        @(posedge tick);
        le_or4_out = 1'b0;
        repeat (quiet) @(posedge tick);
    endtask
endmodule

// [verilog/psc_ctrl.sv]
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// How it works
// [RULE1] The strobe acts only while the mode select is high.
// [RULE2] The host shifts a six-bit word in with the 180-degree bit first.
// [RULE3] A rising strobe after the word is in moves it into the phase state.
// [RULE4] While the strobe is high the serial clock cannot move the shift register.
// [RULE5] The chain output is the serial input delayed by six serial clocks.
// [RULE6] A low mode select switches the serial port off completely; here the shifter still moves on the next two rising serial clock edges.
// [RULE7] In serial mode the three shared pins are strobe, serial clock and data.
// [RULE8] In parallel mode the same three pins are phase bits three, two and one.
// [RULE9] In serial mode the phase state holds while the strobe stays low.
// [RULE10] In parallel mode the six pins set the phase state directly.
// [RULE11] The word is binary weighted in steps of 5.625 degrees from zero.
// [RULE12] A high pin level is a one and a low pin level is a zero.
// [RULE13] The host keeps the serial clock period at 100 ns or more.
// [RULE14] The host spaces strobe pulses at least 630 ns apart.
// [RULE15] Shifting follows the usual serial peripheral style with a word strobe.
// [RULE16] Data is taken and shifted on each rising serial clock edge.
// [RULE17] After power-up the word and shift register are all zeros.
module psc_ctrl (
    // System clock and reset.
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Mode select and dedicated phase pins.
    input wire logic mode_select_in,
    input wire logic phase_bit_step32_in,
    input wire logic phase_bit_step16_in,
    input wire logic phase_bit_step8_in,
    // Shared pins: strobe or bit 3, serial clock or bit 2, serial data or bit 1.
    input wire logic latch_strobe_or_step4_in,
    input wire logic serial_clk_or_step2_in,
    input wire logic serial_in_or_step1_in,
    // Daisy-chain output on the serial clock.
    output logic serial_out_out,
    // Applied phase state and its angle in millidegrees.
    output logic [psc_pkg::WORD_W-1:0] phase_state_out,
    output logic [psc_pkg::ANGLE_W-1:0] phase_angle_out,
    // Register port.
    input wire logic [psc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [psc_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [psc_pkg::DATA_W-1:0] reg_rdata_out
);
    import psc_pkg::*;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] offs);
        addr_hit = (addr == offs);
    endfunction

    // Pin synchronisation.
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic mode_link;
    wire mode_s;
    wire le_s;
    wire [WORD_W-1:0] par_word;

    // Phase state.
    logic [WORD_W-1:0] phase_reg;
    logic [WORD_W-1:0] phase_next;
    logic [ANGLE_W-1:0] angle_reg;
    logic [ANGLE_W-1:0] angle_next;
    logic le_dly_reg;
    wire le_rise;

    // Strobe bookkeeping.
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [GAP_W-1:0] gap_reg;
    logic [GAP_W-1:0] gap_next;
    logic armed_reg;
    logic err_reg;
    wire err_set;
    wire err_next;

    // Register port.
    logic ctrl_en_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rd_word;
    wire wr_ctrl;
    wire cnt_clr;
    wire err_clr;
    wire [DATA_W-1:0] rdata_next;

    psc_link_if lnk ();

    // [RULE12] high means one
    assign pins_raw = {mode_select_in, phase_bit_step32_in, phase_bit_step16_in,
                       phase_bit_step8_in, latch_strobe_or_step4_in,
                       serial_clk_or_step2_in, serial_in_or_step1_in};

    psc_sync #(
        .W(PIN_W)
    ) u_pin_sync (
        .clk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    // The shifter needs the mode in its own domain; its synchroniser only moves while the
    // serial clock runs, so the first two serial clocks after a mode change still use the old mode.
    psc_sync #(
        .W(1)
    ) u_mode_sync (
        .clk_in(serial_clk_or_step2_in),
        .rst_b_in(rst_b_in),
        .d_in(mode_select_in),
        .q_out(mode_link)
    );

    // [RULE7] shared pins serial
    // [RULE15] serial peripheral shifting
    psc_shifter u_shifter (
        .sclk_in(serial_clk_or_step2_in),
        .rst_b_in(rst_b_in),
        .serial_in(serial_in_or_step1_in),
        .latch_in(latch_strobe_or_step4_in),
        .mode_in(mode_link),
        .lnk(lnk)
    );

    assign serial_out_out = lnk.chain_bit;

    assign mode_s = pins_s[PIN_MODE];
    assign le_s = pins_s[PIN_LE];
    // [RULE8] shared pins parallel
    assign par_word = pins_s[WORD_W-1:0];

    // [RULE1] strobe ignored for mode
    assign le_rise = mode_s & le_s & ~le_dly_reg;

    // The shift register is frozen once the strobe is high, so the word can
    // be taken across domains at the synced edge, a few system clocks after the pin edge.
    // [RULE3] strobe loads word
    // [RULE9] hold while low
    // [RULE10] parallel drives directly
    assign phase_next = !mode_s ? par_word : (le_rise ? lnk.word : phase_reg);

    // [RULE11] binary weighted angle
    assign angle_next = {{(ANGLE_W - WORD_W){1'b0}}, phase_reg} * STEP_MDEG;

    // [RULE17] zero at start
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= PHASE_RESET;
            angle_reg <= '0;
            le_dly_reg <= 1'h0;
        end else begin
            phase_reg <= phase_next;
            angle_reg <= angle_next;
            le_dly_reg <= le_s;
        end
    end

    assign phase_state_out = phase_reg;
    assign phase_angle_out = angle_reg;

    // Strobe count; an increment in the clearing cycle is kept.
    assign cnt_next = cnt_clr ? CNT_W'(le_rise & ctrl_en_reg)
                    : (le_rise & ctrl_en_reg) ? CNT_W'(cnt_reg + 16'h0001) : cnt_reg;

    // The gap is measured on synchronised strobes and may be off by a cycle.
    // [RULE14] strobe spacing check
    assign gap_next = le_rise ? GAP_W'(1) : (gap_reg < LE_GAP_CYC ? GAP_W'(gap_reg + 8'h01)
                    : gap_reg);
    assign err_set = le_rise & armed_reg & (gap_reg < LE_GAP_CYC);
    assign err_next = err_set | (err_reg & ~err_clr);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_reg <= '0;
            gap_reg <= '0;
            armed_reg <= 1'h0;
            err_reg <= 1'h0;
        end else begin
            cnt_reg <= cnt_next;
            gap_reg <= gap_next;
            armed_reg <= armed_reg | le_rise;
            err_reg <= err_next;
        end
    end

    // Register writes.
    assign wr_ctrl = reg_wr_in & addr_hit(reg_addr_in, REG_CTRL);
    assign cnt_clr = wr_ctrl & reg_wdata_in[CTRL_CNT_CLR];
    assign err_clr = wr_ctrl & reg_wdata_in[CTRL_ERR_CLR];

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_en_reg <= CTRL_CNT_EN_RESET;
        end else if (wr_ctrl) begin
            ctrl_en_reg <= reg_wdata_in[CTRL_CNT_EN];
        end
    end

    // Register reads; unmapped offsets read as zero.
    always_comb begin
        rd_word = '0;
        if (addr_hit(reg_addr_in, REG_CTRL)) begin
            rd_word[CTRL_CNT_EN] = ctrl_en_reg;
        end else if (addr_hit(reg_addr_in, REG_STATUS)) begin
            rd_word[WORD_W-1:0] = phase_reg;
            rd_word[STAT_MODE] = mode_s;
            rd_word[STAT_ERR] = err_reg;
        end else if (addr_hit(reg_addr_in, REG_COUNT)) begin
            rd_word[CNT_W-1:0] = cnt_reg;
        end else if (addr_hit(reg_addr_in, REG_ANGLE)) begin
            rd_word[ANGLE_W-1:0] = angle_reg;
        end
    end

    assign rdata_next = reg_rd_in ? rd_word : '0;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    strobe_load_a: assert property ( // [RULE3]
        le_rise |=> phase_reg == $past(lnk.word))
        else $error("Strobe edge did not load the shifted word.");
    serial_hold_a: assert property ( // [RULE9]
        mode_s && !le_s |=> $stable(phase_reg))
        else $error("Phase changed in serial mode with the strobe low.");
    parallel_follow_a: assert property ( // [RULE10]
        !mode_s |=> phase_reg == $past(par_word))
        else $error("Phase did not follow the parallel pins.");
    shared_bits_a: assert property ( // [RULE8]
        !mode_s ##1 !mode_s |-> phase_reg[PIN_LE:0] == $past(pins_s[PIN_LE:0]))
        else $error("Shared pins were not used as low phase bits.");
    strobe_count_a: assert property ( // [RULE7]
        le_rise && ctrl_en_reg && !cnt_clr |=> cnt_reg == CNT_W'($past(cnt_reg) + 16'h0001))
        else $error("Strobe on the shared pin was not counted.");
    mode_only_a: assert property ( // [RULE1]
        $rose(le_s) && !mode_s |=> $stable(cnt_reg) && !err_reg || $past(err_reg))
        else $error("Strobe acted outside serial mode.");
    angle_weight_a: assert property ( // [RULE11]
        ##1 1 |-> angle_reg == $past({{(ANGLE_W - WORD_W){1'b0}}, phase_reg}) * STEP_MDEG)
        else $error("Angle is not the phase word times the step.");
    reset_zero_a: assert property ( // [RULE17]
        $rose(rst_b_in) |-> phase_reg == PHASE_RESET && angle_reg == '0)
        else $error("Phase not zero after reset.");
    spacing_flag_a: assert property ( // [RULE14]
        le_rise && armed_reg && gap_reg < LE_GAP_CYC |=> err_reg [*2] or err_clr)
        else $error("Close strobes did not raise the spacing flag.");
    read_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("Read data stood outside the read answer cycle.");
    status_read_a: assert property (
        reg_rd_in && addr_hit(reg_addr_in, REG_STATUS) |=>
            reg_rdata_out[WORD_W-1:0] == $past(phase_reg))
        else $error("Status read did not return the phase.");

    serial_update_c: cover property (
        mode_s && le_rise ##1 phase_reg != $past(phase_reg));
    parallel_change_c: cover property (
        !mode_s ##1 phase_reg != $past(phase_reg));
    spacing_error_c: cover property (err_set);
    mode_switch_c: cover property ($fell(mode_s) ##[1:20] $rose(mode_s));
endmodule

// [verilog/psc_shifter.sv]
`timescale 1ns/10ps
module psc_shifter (
    // Serial clock domain.
    input wire logic sclk_in,
    input wire logic rst_b_in,
    // Link-side inputs, timed against the serial clock by the host.
    input wire logic serial_in,
    input wire logic latch_in,
    input wire logic mode_in,
    // Word and chain bit towards the core.
    psc_link_if.shifter lnk
);
    import psc_pkg::*;

    logic [WORD_W-1:0] sr_reg;
    logic [WORD_W-1:0] sr_next;
    wire shift_en;

    // [RULE4] strobe masks clock
    // [RULE6] serial port off
    assign shift_en = mode_in & ~latch_in;
    // [RULE16] rising-edge shift
    assign sr_next = shift_en ? {sr_reg[WORD_W-2:0], serial_in} : sr_reg;

    // [RULE17] zero at start
    always_ff @(posedge sclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sr_reg <= PHASE_RESET;
        end else begin
            sr_reg <= sr_next;
        end
    end

    // [RULE5] six-cycle chain
    assign lnk.chain_bit = sr_reg[WORD_W-1];
    assign lnk.word = sr_reg;

    chain_delay_a: assert property ( // [RULE5]
        @(posedge sclk_in) disable iff (!rst_b_in)
        shift_en [*6] |=> lnk.chain_bit == $past(serial_in, 6))
        else $error("Chain output is not the input six clocks back.");
    shift_in_a: assert property ( // [RULE16]
        @(posedge sclk_in) disable iff (!rst_b_in)
        shift_en |=> sr_reg[0] == $past(serial_in) && sr_reg[5:1] == $past(sr_reg[4:0]))
        else $error("Shift register did not take the serial bit.");
    latch_mask_a: assert property ( // [RULE4]
        @(posedge sclk_in) disable iff (!rst_b_in)
        mode_in && latch_in |=> $stable(sr_reg))
        else $error("Shift register moved while the strobe was high.");
    port_off_a: assert property ( // [RULE6]
        @(posedge sclk_in) disable iff (!rst_b_in)
        !mode_in |=> $stable(sr_reg))
        else $error("Shift register moved in parallel mode.");
    full_word_c: cover property (
        @(posedge sclk_in) disable iff (!rst_b_in)
        shift_en [*6] ##1 latch_in);
endmodule

// [verilog/psc_sync.sv]
`timescale 1ns/10ps
module psc_sync #(
    parameter int W = 1
) (
    // Destination clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Asynchronous level in, synchronised level out.
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= '0;
            q_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule
